// ---- core/mfs_top.sv ----
// Multi-phase fault supervisor and start-up sequencer
// Function
// - Power-good drops after range fault persists the full 250 us; overvoltage or lockout drops it at once.
// - Output counts in range between half target and target plus 80 mV.
// - Gates stay low until supply reaches 9 V, off again below 8 V.
// - Gates stay low until the error amplifier reaches 0.6 V.
// - Per-phase pulse limit ends only that phase's present pulse.
// - Averaged current over limit latches a fault until power cycles.
// - Code 11111X stops switching until a valid code returns.
// - Six-bit code sets the target, reference 20 mV below nominal.
// - Phase spacing adjusts itself to the enabled phase count.
// - Four phases fire in sequence 90 degrees apart.
// - Phase four strapped to supply gives phases 1-2-3 at 120 degrees.
// - Phases one and three grounded leaves phases two and four.
// - Faults stop switching, discharge soft-start, drop driver enable; overvoltage keeps driver enable high.
// - Sense out of range forces power-good low only; overvoltage also stops switching.
// - After overvoltage, gates stay off and latch holds until power-on.
`timescale 1ns/1ps
`default_nettype none
module mfs_top #(
  parameter int PG_DELAY_CYC = mfs_pkg::PG_DELAY_CYC
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic supply_above_on_in,
  input wire logic supply_below_off_in,
  input wire logic comp_above_release_in,
  input wire logic window_sense_above_low_in,
  input wire logic window_sense_below_high_in,
  input wire logic overvoltage_trip_in,
  input wire logic enable_in,
  input wire logic average_current_limit_ref_exceeded_in,
  input wire logic reference_undervoltage_in,
  input wire logic phase_four_sense_strap_in,
  input wire logic phase_one_three_sense_ground_in,
  input wire logic [mfs_pkg::CODE_W-1:0] voltage_select_code_in,
  input wire logic [3:0] modulator_request_in,
  input wire logic [3:0] phase_pulse_limit_in,
  output logic [3:0] phase_gate_output_out,
  output logic driver_enable_out,
  output logic output_in_range_flag_out,
  output logic soft_start_discharge_out,
  output logic fault_latched_out,
  output logic shutdown_code_out,
  output logic [3:0] active_phases_out,
  output logic [mfs_pkg::CODE_W-1:0] reference_code_out,
  output logic [4:0] reference_offset_mv_out
);
  import mfs_pkg::*;

  // ---------------------------------------------------------------
  // Reset release and input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_ff_q;
  logic rst_n;
  logic [SYNC_W-1:0] raw, meta_q, sync_q;

  // Reset is released through two flip-flops
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_ff_q <= 2'h0;
    end else begin
      rst_ff_q <= {rst_ff_q[0], 1'b1};
    end
  end
  assign rst_n = rst_ff_q[1];

  assign raw = {supply_above_on_in, supply_below_off_in,
                comp_above_release_in, window_sense_above_low_in,
                window_sense_below_high_in, overvoltage_trip_in, enable_in,
                average_current_limit_ref_exceeded_in,
                reference_undervoltage_in, phase_four_sense_strap_in,
                phase_one_three_sense_ground_in, voltage_select_code_in,
                modulator_request_in, phase_pulse_limit_in};

  // Two flip-flops per comparator bit
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  logic vcc_on_s, vcc_off_s, comp_ok_s, win_lo_s, win_hi_s, ovp_s, en_s;
  logic avg_oc_s, vref_uv_s, strap4_s, strap13_s;
  logic [CODE_W-1:0] code_s;
  logic [3:0] pwm_s, plim_s;
  assign {vcc_on_s, vcc_off_s, comp_ok_s, win_lo_s, win_hi_s, ovp_s, en_s,
          avg_oc_s, vref_uv_s, strap4_s, strap13_s, code_s, pwm_s,
          plim_s} = sync_q;

  // ---------------------------------------------------------------
  // Lockout, latched faults and shutdown code
  // ---------------------------------------------------------------
  logic uvlo_ok_q, ovp_lat_q, oc_lat_q, vref_lat_q;
  logic code_fault, latched, stop;

  // Hysteretic lockout between the two supply thresholds
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      uvlo_ok_q <= 1'b0;
    end else if (vcc_off_s) begin
      uvlo_ok_q <= 1'b0;
    end else if (vcc_on_s) begin
      uvlo_ok_q <= 1'b1;
    end
  end

  // Latched faults clear only by power-on reset
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ovp_lat_q <= 1'b0;
      oc_lat_q <= 1'b0;
      vref_lat_q <= 1'b0;
    end else if (uvlo_ok_q) begin
      ovp_lat_q <= ovp_lat_q | ovp_s;
      oc_lat_q <= oc_lat_q | avg_oc_s;
      vref_lat_q <= vref_lat_q | vref_uv_s;
    end
  end

  assign code_fault = (code_s[CODE_W-1:1] == SHUTDOWN_CODE_TOP);
  assign latched = ovp_lat_q | oc_lat_q | vref_lat_q;
  assign stop = latched | code_fault | !en_s;

  // Last valid code becomes the regulation reference
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reference_code_out <= RST_REF_CODE;
      reference_offset_mv_out <= REF_OFFSET_MV;
    end else begin
      if (!code_fault) begin
        reference_code_out <= code_s;
      end
      reference_offset_mv_out <= REF_OFFSET_MV;
    end
  end

  // ---------------------------------------------------------------
  // Supervisor state machine
  // ---------------------------------------------------------------
  mfs_state_t state_q;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_LOCKOUT;
    end else if (!uvlo_ok_q) begin
      state_q <= ST_LOCKOUT;
    end else begin
      case (state_q)
        ST_LOCKOUT: begin
          state_q <= stop ? ST_HALT : ST_SOFTSTART;
        end
        ST_SOFTSTART: begin
          if (stop) begin
            state_q <= ST_HALT;
          end else if (comp_ok_s) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (stop) begin
            state_q <= ST_HALT;
          end
        end
        ST_HALT: begin
          if (!stop) begin
            state_q <= ST_SOFTSTART;
          end
        end
        default: begin
          state_q <= ST_LOCKOUT;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Phase count strapping
  // ---------------------------------------------------------------
  mfs_phase_if ph_bus ();
  mfs_nph_t cfg_q;
  logic strap_taken_q;
  logic [3:0] phase_en;

  // Straps taken once when the lockout first releases
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= NPH_FOUR;
      strap_taken_q <= 1'b0;
    end else if (uvlo_ok_q && !strap_taken_q) begin
      strap_taken_q <= 1'b1;
      if (strap13_s) begin
        cfg_q <= NPH_TWO;
      end else if (strap4_s) begin
        cfg_q <= NPH_THREE;
      end else begin
        cfg_q <= NPH_FOUR;
      end
    end
  end
  assign ph_bus.cfg = cfg_q;

  always_comb begin
    case (cfg_q)
      NPH_THREE: phase_en = EN_THREE;
      NPH_TWO: phase_en = EN_TWO;
      default: phase_en = EN_FOUR;
    endcase
  end

  mfs_phase_seq u_seq (
    .clk_in (sys_clk_in),
    .rst_n_in (rst_n),
    .bus (ph_bus.seq)
  );

  // ---------------------------------------------------------------
  // Gate outputs
  // ---------------------------------------------------------------
  logic run;
  assign run = uvlo_ok_q && (state_q == ST_RUN) && !stop;

  generate
    for (gi = 0; gi < 4; gi++) begin : g_gate
      // Pulse opens at its slot, ends with the modulator or the limit
      always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          phase_gate_output_out[gi] <= 1'b0;
        end else if (!run || !phase_en[gi] || plim_s[gi]) begin
          phase_gate_output_out[gi] <= 1'b0;
        end else if (ph_bus.slot_start[gi]) begin
          phase_gate_output_out[gi] <= pwm_s[gi];
        end else if (!pwm_s[gi]) begin
          phase_gate_output_out[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      driver_enable_out <= 1'b0;
      soft_start_discharge_out <= 1'b1;
      fault_latched_out <= 1'b0;
      shutdown_code_out <= 1'b0;
      active_phases_out <= 4'h0;
    end else begin
      driver_enable_out <= uvlo_ok_q & (ovp_lat_q | !stop);
      soft_start_discharge_out <= !uvlo_ok_q | stop;
      fault_latched_out <= latched;
      shutdown_code_out <= code_fault;
      active_phases_out <= strap_taken_q ? phase_en : 4'h0;
    end
  end

  // Window comparators feed the persistence filter
  mfs_pg_filter #(
    .DELAY_CYC (PG_DELAY_CYC)
  ) u_pg (
    .clk_in (sys_clk_in),
    .rst_n_in (rst_n),
    .bad_in (!(win_lo_s && win_hi_s)),
    .force_low_in (ovp_s | ovp_lat_q),
    .allow_in (uvlo_ok_q),
    .pg_out (output_in_range_flag_out)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_lockout_gates;
    @(posedge sys_clk_in) disable iff (!rst_n)
      !uvlo_ok_q |=> (phase_gate_output_out == 4'h0);
  endproperty
  a_lockout_gates: assert property (p_lockout_gates)
    else $error("gate active during supply lockout");
  property p_softstart_gates;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (phase_gate_output_out != 4'h0) |-> $past(state_q) == ST_RUN;
  endproperty
  a_softstart_gates: assert property (p_softstart_gates)
    else $error("gate active before soft-start release");
  property p_pulse_limit;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (plim_s != 4'h0) |=> ((phase_gate_output_out & $past(plim_s)) == 4'h0);
  endproperty
  a_pulse_limit: assert property (p_pulse_limit)
    else $error("limited phase kept its pulse");
  property p_oc_latch;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (avg_oc_s && uvlo_ok_q) |=> ##1 fault_latched_out ##1 fault_latched_out;
  endproperty
  a_oc_latch: assert property (p_oc_latch)
    else $error("over-current did not latch");
  property p_code_stop;
    @(posedge sys_clk_in) disable iff (!rst_n)
      code_fault |=> (phase_gate_output_out == 4'h0) && soft_start_discharge_out;
  endproperty
  a_code_stop: assert property (p_code_stop)
    else $error("shutdown code did not stop switching");
  property p_ovp_driver;
    @(posedge sys_clk_in) disable iff (!rst_n)
      (ovp_lat_q && uvlo_ok_q) |=> driver_enable_out && !$rose(state_q[2]);
  endproperty
  a_ovp_driver: assert property (p_ovp_driver)
    else $error("driver enable dropped on overvoltage");
  property p_ovp_pg;
    @(posedge sys_clk_in) disable iff (!rst_n)
      ovp_s |=> !output_in_range_flag_out;
  endproperty
  a_ovp_pg: assert property (p_ovp_pg)
    else $error("power-good high during overvoltage");
  property p_ovp_hold;
    @(posedge sys_clk_in) disable iff (!rst_n)
      ovp_lat_q |=> ovp_lat_q && (phase_gate_output_out == 4'h0);
  endproperty
  a_ovp_hold: assert property (p_ovp_hold)
    else $error("overvoltage latch released or gate on");
  property p_strap_hold;
    @(posedge sys_clk_in) disable iff (!rst_n)
      strap_taken_q |=> $stable(cfg_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("phase configuration changed after sampling");
endmodule : mfs_top
`default_nettype wire

// ---- core/mfs_pkg.sv ----
// Constants and types shared by the fault supervisor modules
package mfs_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PG_DELAY_US = 250;
  localparam int PG_DELAY_CYC = (PG_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int PG_CNT_W = 15;
  localparam int SWITCH_PERIOD_NS = 1200;
  localparam int SWITCH_PERIOD_CYC = SWITCH_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [7:0] SLOT_FOUR_CYC = 8'(SWITCH_PERIOD_CYC / 4);
  localparam logic [7:0] SLOT_THREE_CYC = 8'(SWITCH_PERIOD_CYC / 3);
  localparam logic [7:0] SLOT_TWO_CYC = 8'(SWITCH_PERIOD_CYC / 2);
  // ---------------------------------------------------------------
  // Analog thresholds, held for reference by the comparators
  // ---------------------------------------------------------------
  localparam int UVLO_ON_MV = 9000;
  localparam int UVLO_OFF_MV = 8000;
  localparam int COMP_RELEASE_MV = 600;
  localparam int PG_UPPER_OFFSET_MV = 80;
  localparam logic [4:0] REF_OFFSET_MV = 5'h14;
  // ---------------------------------------------------------------
  // Codes, widths and reset values
  // ---------------------------------------------------------------
  localparam int CODE_W = 6;
  localparam logic [4:0] SHUTDOWN_CODE_TOP = 5'h1f;
  localparam logic [5:0] RST_REF_CODE = 6'h00;
  localparam int SYNC_W = 25;
  localparam logic [3:0] EN_FOUR = 4'hf;
  localparam logic [3:0] EN_THREE = 4'h7;
  localparam logic [3:0] EN_TWO = 4'ha;
  // Phase count taken from the strapping
  typedef enum logic [2:0] {
    NPH_FOUR = 3'b001,
    NPH_THREE = 3'b010,
    NPH_TWO = 3'b100
  } mfs_nph_t;
  // Supervisor states
  typedef enum logic [3:0] {
    ST_LOCKOUT = 4'b0001,
    ST_SOFTSTART = 4'b0010,
    ST_RUN = 4'b0100,
    ST_HALT = 4'b1000
  } mfs_state_t;
endpackage : mfs_pkg

// ---- core/mfs_phase_if.sv ----
// Interface between the supervisor and the phase sequencer
`timescale 1ns/1ps
`default_nettype none
interface mfs_phase_if;
  import mfs_pkg::*;
  mfs_nph_t cfg;
  logic [3:0] slot_start;
  modport seq (input cfg, output slot_start);
  modport ctl (output cfg, input slot_start);
endinterface : mfs_phase_if
`default_nettype wire

// ---- core/mfs_phase_seq.sv ----
// Phase firing sequencer with automatic even spacing
`timescale 1ns/1ps
`default_nettype none
module mfs_phase_seq (
  input wire logic clk_in,
  input wire logic rst_n_in,
  mfs_phase_if.seq bus
);
  import mfs_pkg::*;
  logic [7:0] slot_cnt_q;
  logic [1:0] idx_q;
  logic [7:0] slot_len;
  logic [1:0] last_idx;
  logic [3:0] start_d;
  logic [3:0] start_q;

  // Slot length and count follow the phase count
  always_comb begin
    case (bus.cfg)
      NPH_THREE: begin
        slot_len = SLOT_THREE_CYC;
        last_idx = 2'h2;
      end
      NPH_TWO: begin
        slot_len = SLOT_TWO_CYC;
        last_idx = 2'h1;
      end
      default: begin
        slot_len = SLOT_FOUR_CYC;
        last_idx = 2'h3;
      end
    endcase
  end

  // Slot timer and slot index
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slot_cnt_q <= 8'h00;
      idx_q <= 2'h0;
    end else if (slot_cnt_q == slot_len - 8'h01) begin
      slot_cnt_q <= 8'h00;
      idx_q <= (idx_q == last_idx) ? 2'h0 : idx_q + 2'h1;
    end else begin
      slot_cnt_q <= slot_cnt_q + 8'h01;
    end
  end

  // Map slot index onto the phase that fires
  always_comb begin
    start_d = 4'h0;
    if (slot_cnt_q == 8'h00) begin
      if (bus.cfg == NPH_TWO) begin
        start_d[{idx_q[0], 1'b1}] = 1'b1;
      end else begin
        start_d[idx_q] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_q <= 4'h0;
    end else begin
      start_q <= start_d;
    end
  end
  assign bus.slot_start = start_q;

  property p_four_spacing;
    @(posedge clk_in) disable iff (!rst_n_in)
      (bus.cfg == NPH_FOUR && start_q[1]) |-> $past(start_q[0], 30);
  endproperty
  a_four_spacing: assert property (p_four_spacing)
    else $error("four-phase spacing is not a quarter period");
endmodule : mfs_phase_seq
`default_nettype wire

// ---- core/mfs_pg_filter.sv ----
// Power-good persistence filter
`timescale 1ns/1ps
`default_nettype none
module mfs_pg_filter #(
  parameter int DELAY_CYC = mfs_pkg::PG_DELAY_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic bad_in,
  input wire logic force_low_in,
  input wire logic allow_in,
  output logic pg_out
);
  import mfs_pkg::*;
  localparam logic [PG_CNT_W-1:0] LAST = PG_CNT_W'(DELAY_CYC - 1);
  logic [PG_CNT_W-1:0] cnt_q;
  logic pg_q;

  // Bad must persist the whole delay before the flag drops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      pg_q <= 1'b0;
    end else if (force_low_in || !allow_in) begin
      cnt_q <= '0;
      pg_q <= 1'b0;
    end else if (bad_in) begin
      if (cnt_q == LAST) begin
        pg_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end else begin
      cnt_q <= '0;
      pg_q <= 1'b1;
    end
  end
  assign pg_out = pg_q;

  property p_no_early_drop;
    @(posedge clk_in) disable iff (!rst_n_in)
      (pg_q && !force_low_in && allow_in && cnt_q != LAST) |=> pg_q;
  endproperty
  a_no_early_drop: assert property (p_no_early_drop)
    else $error("power-good dropped before the delay ran out");

  property p_restart;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!bad_in) |=> (cnt_q == '0);
  endproperty
  a_restart: assert property (p_restart)
    else $error("delay counter did not restart");
endmodule : mfs_pg_filter
`default_nettype wire

// ---- tb/mfs_stage_model.sv ----
// Behavioural gate driver and power stage facing the phase gates
`timescale 1ns/1ps
`default_nettype none
module mfs_stage_model (
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic [3:0] gate_in,
  output logic [3:0] req_out,
  output logic [3:0][7:0] rise_cnt_out,
  output logic [3:0][15:0] rise_at_out
);
  logic [15:0] cyc_q = 16'h0;
  logic [3:0] prev_q = 4'h0;
  logic [3:0][3:0] on_q = '0;
  initial begin
    req_out = 4'hf;
    rise_cnt_out = '0;
    rise_at_out = '0;
  end
  // Modulator ends each pulse eight cycles after the gate opens
  always @(posedge clk_in) begin
    cyc_q <= cyc_q + 16'h1;
    prev_q <= gate_in;
    for (int i = 0; i < 4; i++) begin
      on_q[i] <= gate_in[i] ? on_q[i] + 4'h1 : 4'h0;
      req_out[i] <= !(gate_in[i] && on_q[i] >= 4'h7);
      if (clr_in) begin
        rise_cnt_out[i] <= 8'h0;
      end else if (gate_in[i] && !prev_q[i]) begin
        rise_cnt_out[i] <= rise_cnt_out[i] + 8'h1;
        rise_at_out[i] <= cyc_q;
      end
    end
  end
endmodule : mfs_stage_model
`default_nettype wire

// ---- tb/multiphase_fault_supervisor_tb.sv ----
// Self-checking bench for the multi-phase fault supervisor
`timescale 1ns/1ps
`default_nettype none
module multiphase_fault_supervisor_tb;
  import mfs_pkg::*;
  localparam int PG_CYC = 20;
  logic clk = 1'b0, nrst = 1'b0, sup_on = 1'b0, sup_off = 1'b1;
  logic comp = 1'b0, win_lo = 1'b1, win_hi = 1'b1, overvoltage_trip = 1'b0;
  logic en = 1'b1, avg = 1'b0, refuv = 1'b0, s4 = 1'b0, s13 = 1'b0;
  logic clr = 1'b0;
  logic [5:0] code = 6'h15;
  logic [3:0] lim = 4'h0;
  logic [3:0] req, gate, act;
  logic drv, pg, dis, fault, shut;
  logic [5:0] refc;
  logic [4:0] offs;
  logic [3:0][7:0] cnt;
  logic [3:0][15:0] at;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  // ---------------------------------------------------------------
  // Design, power stage and clock
  // ---------------------------------------------------------------
  mfs_top #(.PG_DELAY_CYC(PG_CYC)) DUT (
    .sys_clk_in(clk), .nrst_in(nrst), .supply_above_on_in(sup_on),
    .supply_below_off_in(sup_off), .comp_above_release_in(comp),
    .window_sense_above_low_in(win_lo), .window_sense_below_high_in(win_hi),
    .overvoltage_trip_in(overvoltage_trip), .enable_in(en),
    .average_current_limit_ref_exceeded_in(avg),
    .reference_undervoltage_in(refuv), .phase_four_sense_strap_in(s4),
    .phase_one_three_sense_ground_in(s13), .voltage_select_code_in(code),
    .modulator_request_in(req), .phase_pulse_limit_in(lim),
    .phase_gate_output_out(gate), .driver_enable_out(drv),
    .output_in_range_flag_out(pg), .soft_start_discharge_out(dis),
    .fault_latched_out(fault), .shutdown_code_out(shut),
    .active_phases_out(act), .reference_code_out(refc),
    .reference_offset_mv_out(offs));
  mfs_stage_model u_stage (.clk_in(clk), .clr_in(clr), .gate_in(gate),
    .req_out(req), .rise_cnt_out(cnt), .rise_at_out(at));
  initial begin
    forever #5 clk = ~clk;
  end
  // Hang guard, well above the length of the sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic look(input int n);
    step(n);
    @(negedge clk);
  endtask : look
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_fired(input logic [3:0] exp);
    for (int i = 0; i < 4; i++) begin
      chk("phase fired", 16'(exp[i]), 16'(cnt[i] != 8'h0));
    end
  endtask : chk_fired
  task automatic chk_space(input int a, input int b, input int exp);
    chk("spacing", 16'(exp), (at[b] + 16'd120 - at[a]) % 16'd120);
  endtask : chk_space
  task automatic clear_counts;
    step(1);
    clr <= 1'b1;
    step(1);
    clr <= 1'b0;
  endtask : clear_counts
  // Fresh reset with the given straps, supply raised, comp still low
  task automatic power_up(input logic strap4, input logic strap13);
    step(1);
    nrst <= 1'b0;
    {sup_on, sup_off, comp, overvoltage_trip, avg, refuv} <= 6'h10;
    {en, win_lo, win_hi, s4, s13} <= {3'h7, strap4, strap13};
    code <= 6'h15;
    lim <= 4'h0;
    step(6);
    nrst <= 1'b1;
    step(3);
    sup_on <= 1'b1;
    sup_off <= 1'b0;
    look(10);
  endtask : power_up
  task automatic run_phases;
    step(1);
    comp <= 1'b1;
    clear_counts();
    look(300);
  endtask : run_phases
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    look(4);
    chk("gate", 16'h0, 16'(gate));
    chk("drv", 16'h0, 16'(drv));
    chk("pg", 16'h0, 16'(pg));
    chk("dis", 16'h1, 16'(dis));
    chk("fault", 16'h0, 16'(fault));
    chk("act", 16'h0, 16'(act));
    chk("ref", 16'h0, 16'(refc));
    chk("offs", 16'h14, 16'(offs));
    $display("test reset done");
    power_up(1'b0, 1'b0);
    chk("gate", 16'h0, 16'(gate));
    chk("act", 16'hf, 16'(act));
    chk("pg", 16'h1, 16'(pg));
    run_phases();
    chk_fired(4'hf);
    for (int i = 0; i < 3; i++) begin
      chk_space(i, i + 1, 30);
    end
    step(1);
    s4 <= 1'b1;
    look(5);
    chk("act", 16'hf, 16'(act));
    $display("test four phases done");
    step(1);
    lim <= 4'h1;
    step(5);
    clear_counts();
    look(300);
    chk_fired(4'he);
    step(1);
    lim <= 4'h0;
    $display("test pulse limit done");
    clear_counts();
    win_hi <= 1'b0;
    step(15);
    win_hi <= 1'b1;
    step(3);
    win_hi <= 1'b0;
    look(15);
    chk("pg", 16'h1, 16'(pg));
    look(110);
    chk("pg", 16'h0, 16'(pg));
    chk("drv", 16'h1, 16'(drv));
    chk_fired(4'hf);
    step(1);
    win_hi <= 1'b1;
    look(5);
    chk("pg", 16'h1, 16'(pg));
    $display("test power good done");
    for (int k = 0; k < 2; k++) begin
      step(1);
      code <= 6'h3e + 6'(k);
      look(6);
      chk("shut", 16'h1, 16'(shut));
      chk("gate", 16'h0, 16'(gate));
      chk("drv", 16'h0, 16'(drv));
      chk("dis", 16'h1, 16'(dis));
      chk("ref", (k == 0) ? 16'h15 : 16'h20, 16'(refc));
      step(1);
      code <= 6'h20;
      look(6);
      chk("shut", 16'h0, 16'(shut));
      chk("drv", 16'h1, 16'(drv));
      chk("ref", 16'h20, 16'(refc));
    end
    step(1);
    en <= 1'b0;
    look(6);
    chk("drv", 16'h0, 16'(drv));
    chk("gate", 16'h0, 16'(gate));
    chk("dis", 16'h1, 16'(dis));
    step(1);
    en <= 1'b1;
    look(6);
    chk("drv", 16'h1, 16'(drv));
    $display("test code and enable done");
    step(1);
    sup_on <= 1'b0;
    clear_counts();
    look(200);
    chk_fired(4'hf);
    step(1);
    sup_off <= 1'b1;
    look(6);
    chk("gate", 16'h0, 16'(gate));
    step(1);
    sup_off <= 1'b0;
    clear_counts();
    look(200);
    chk_fired(4'h0);
    step(1);
    sup_on <= 1'b1;
    clear_counts();
    look(300);
    chk_fired(4'hf);
    $display("test lockout done");
    step(1);
    overvoltage_trip <= 1'b1;
    look(6);
    chk("pg", 16'h0, 16'(pg));
    chk("drv", 16'h1, 16'(drv));
    chk("gate", 16'h0, 16'(gate));
    step(1);
    overvoltage_trip <= 1'b0;
    clear_counts();
    look(200);
    chk("fault", 16'h1, 16'(fault));
    chk("pg", 16'h0, 16'(pg));
    chk_fired(4'h0);
    $display("test overvoltage done");
    for (int k = 0; k < 2; k++) begin
      power_up(1'b0, 1'b0);
      run_phases();
      step(1);
      {avg, refuv} <= (k == 0) ? 2'b10 : 2'b01;
      step(5);
      {avg, refuv} <= 2'b00;
      clear_counts();
      look(200);
      chk("fault", 16'h1, 16'(fault));
      chk("drv", 16'h0, 16'(drv));
      chk("dis", 16'h1, 16'(dis));
      chk_fired(4'h0);
    end
    $display("test latched faults done");
    power_up(1'b1, 1'b0);
    chk("act", 16'h7, 16'(act));
    run_phases();
    chk_fired(4'h7);
    chk_space(0, 1, 40);
    chk_space(1, 2, 40);
    step(1);
    s4 <= 1'b0;
    look(5);
    chk("act", 16'h7, 16'(act));
    power_up(1'b0, 1'b1);
    chk("act", 16'ha, 16'(act));
    run_phases();
    chk_fired(4'ha);
    chk_space(1, 3, 60);
    $display("test strapping done");
    tally_and_finish();
  end
endmodule : multiphase_fault_supervisor_tb
`default_nettype wire
